//--- host_model.sv
// Model of the serial host controller that drives the control port.
// Assumes the bench resolves the data pin from both enables.
`timescale 1ns/1ps
`default_nettype none

module host_model (
   // Bench clock, used only to pace the link
   input  wire logic clock,
   // Pin levels seen by the host
   input  wire logic dataWire,
   input  wire logic readPinWire,
   // Pins driven by the host
   output logic      sclk,
   output logic      csN,
   output logic      hostBit,
   output logic      hostOe
);
   initial begin
      sclk = 1'b0;
      csN = 1'b1;
      hostBit = 1'b0;
      hostOe = 1'b0;
   end

   task automatic ticks(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : ticks

   // Each link level lasts four clocks; read bits are sampled late in the
   // high phase because the device answers a few clocks after the fall
   task automatic shift(input logic lsb, input logic sep, input int nb,
                        input logic [15:0] w, output logic [15:0] r);
      int idx;
      r = 16'h0000;
      for (int i = 0; i < nb; i++) begin
         idx = lsb ? i : nb - 1 - i;
         hostBit = w[idx];
         ticks(4);
         sclk = 1'b1;
         ticks(3);
         r[idx] = sep ? readPinWire : dataWire;
         ticks(1);
         sclk = 1'b0;
      end
   endtask : shift

   // One frame: 16-bit instruction, then nBytes bytes, first byte lowest
   task automatic frame(input logic lsb, input logic sep,
                        input logic [15:0] instr, input int nBytes,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic [15:0] got;
      rd = 16'h0000;
      csN = 1'b0;
      hostOe = 1'b1;
      ticks(4);
      shift(lsb, sep, 16, instr, got);
      hostOe = ~instr[15];
      for (int k = 0; k < nBytes; k++) begin
         shift(lsb, sep, 8, {8'h00, wd[8*k +: 8]}, got);
         rd[8*k +: 8] = got[7:0];
      end
      ticks(4);
      csN = 1'b1;
      hostOe = 1'b0;
      ticks(6);
   endtask : frame
endmodule : host_model
`default_nettype wire

//--- pin_sync.sv
// Two-flop synchroniser with edge detection for asynchronous pins.
// Assumes pins change slowly against the clock (several clocks per level).
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   // Pins and synchronised view
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;
   logic [WIDTH-1:0] prev_ff;

   // Edges come from the second and third stages only
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_ff <= '1;
         sync_ff <= '1;
         prev_ff <= '1;
      end else begin
         meta_ff <= pinIn;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign level = sync_ff;
   assign rise  = sync_ff & ~prev_ff;
   assign fall  = ~sync_ff & prev_ff;

endmodule : pin_sync

`default_nettype wire

//--- serial_cfg_pkg.sv
// Constants for the serial configuration port: register map, field
// positions, reset values, frame layout and engine states.
// Assumes a 16-bit instruction word followed by whole data bytes.
package serial_cfg_pkg;

   localparam int ADDR_W = 13;

   // Register map
   localparam logic [12:0] ADDR_PORT_CFG = 13'h000;
   localparam logic [12:0] ADDR_VARIANT  = 13'h003;
   localparam logic [12:0] ADDR_READBACK = 13'h004;
   localparam logic [12:0] ADDR_UPDATE   = 13'h232;

   // Port configuration, readback and update fields (port configuration upper nibble mirrors the lower one)
   localparam int BIT_SEP_READ   = 0;
   localparam int BIT_LSB_FIRST  = 1;
   localparam int BIT_SOFT_RESET = 2;
   localparam int BIT_LONG_INSTR = 3;
   localparam int BIT_READ_ACT   = 0;
   localparam int BIT_UPDATE     = 0;

   // Reset values: long instruction set, and its mirror
   localparam logic [7:0] PORT_CFG_RST  = 8'h18;
   // Held while soft reset is pending: defaults plus the reset bit pair
   localparam logic [7:0] PORT_CFG_HELD = 8'h3C;
   localparam logic [7:0] READBACK_RST  = 8'h00;

   // Instruction layout: read flag, byte count, address
   localparam int INSTR_RW = 15;
   localparam int CNT_HI   = 14;
   localparam int CNT_LO   = 13;
   localparam logic [1:0] CNT_STREAM = 2'h3;
   localparam logic [3:0] LAST_INSTR_BIT = 4'hF;
   localparam logic [3:0] LAST_BYTE_BIT  = 4'h7;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_INSTR,
      ST_WRITE,
      ST_READ,
      ST_DONE
   } engine_state_t;

endpackage : serial_cfg_pkg

//--- serial_config_port.sv
// Serial control port with its configuration registers, double-buffered.
// Assumes the host keeps each link clock level for at least three clocks
// and lowers the select at least one clock before the first link edge.
// Function
// RL1: Host writes upper nibble mirroring lower nibble.
// RL2: Instruction length bit; only 16-bit supported.
// RL3: Soft reset restores defaults until cleared.
// RL4: Bit order selects MSB/LSB first, address step.
// RL5: Pin mode selects shared or separate read pin.
// RL6: Fixed read-only variant identifier byte.
// RL7: Readback select returns buffer or active copy.
// RL8: Writes fill buffer; update copies to active.
`timescale 1ns/1ps
`default_nettype none

module serial_config_port #(
   // Arbitrary value, not a real part code
   parameter logic [7:0] VARIANT_ID = 8'hA5
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // Serial link pins
   input  wire logic       sclk,
   input  wire logic       csN,
   input  wire logic       sdioIn,
   output logic            sdioOut,
   output logic            sdioOe,
   output logic            serialReadOutPin,
   output logic            separateReadPinEnable,
   // Active configuration and buffered soft reset flag seen by the rest of the device
   output logic [7:0]      activePortCfg,
   output logic [7:0]      activeReadback,
   output logic            softResetHeld
);

   logic [2:0] pinLevel;
   logic [2:0] pinRise;
   logic [2:0] pinFall;

   pin_sync #(.WIDTH(3)) u_sync (
      .clock (clock),
      .rst   (rst),
      .pinIn ({sdioIn, csN, sclk}),
      .level (pinLevel),
      .rise  (pinRise),
      .fall  (pinFall)
   );

   logic sclkRise, sclkFall, csHigh, dataBit;
   assign sclkRise = pinRise[0];
   assign sclkFall = pinFall[0];
   assign csHigh   = pinLevel[1];
   assign dataBit  = pinLevel[2];

   serial_cfg_pkg::engine_state_t state_ff, nxt_state;
   logic [3:0]  bitCnt_ff, nxt_bitCnt;
   logic [15:0] shift_ff, nxt_shift;
   logic [7:0]  outShift_ff, nxt_outShift;
   logic [12:0] addr_ff, nxt_addr;
   logic [1:0]  count_ff, nxt_count;
   logic [1:0]  bytesDone_ff, nxt_bytesDone;
   logic        sdioOut_ff, nxt_sdioOut, sdioOe_ff, nxt_sdioOe;
   logic        sdoOut_ff, nxt_sdoOut, sdoOe_ff, nxt_sdoOe;
   logic [7:0]  cfgBuf_ff, nxt_cfgBuf, cfgAct_ff, nxt_cfgAct;
   logic [7:0]  rbBuf_ff, nxt_rbBuf, rbAct_ff, nxt_rbAct;
   logic        wrStrobe;
   logic [7:0]  wrData;
   logic [15:0] shifted;
   logic        lsbFirst, lastByte;

   function automatic logic [15:0] shiftIn(input logic [15:0] w,
                                           input logic b,
                                           input logic lsb);
      shiftIn = lsb ? {b, w[15:1]} : {w[14:0], b};
   endfunction : shiftIn

   function automatic logic [12:0] stepAddr(input logic [12:0] a,
                                            input logic lsb);
      stepAddr = lsb ? 13'(a + 13'h1) : 13'(a - 13'h1);
   endfunction : stepAddr

   // Serial read view; the update control always reads back as zero
   function automatic logic [7:0] readData(input logic [12:0] a);
      logic act;
      act = rbAct_ff[serial_cfg_pkg::BIT_READ_ACT];
      case (a)
         serial_cfg_pkg::ADDR_PORT_CFG: readData = act ? cfgAct_ff : cfgBuf_ff;
         serial_cfg_pkg::ADDR_VARIANT:  readData = VARIANT_ID; // RL6
         serial_cfg_pkg::ADDR_READBACK: readData = act ? rbAct_ff : rbBuf_ff;
         default:                       readData = 8'h00;
      endcase
   endfunction : readData

   assign lsbFirst = cfgAct_ff[serial_cfg_pkg::BIT_LSB_FIRST]; // RL4
   assign shifted  = shiftIn(shift_ff, dataBit, lsbFirst);
   assign lastByte = (count_ff != serial_cfg_pkg::CNT_STREAM)
                     && (bytesDone_ff == count_ff);
   assign wrStrobe = (state_ff == serial_cfg_pkg::ST_WRITE) && sclkRise
                     && (bitCnt_ff == serial_cfg_pkg::LAST_BYTE_BIT);
   assign wrData   = lsbFirst ? shifted[15:8] : shifted[7:0];

   // Serial engine. Only the 16-bit instruction form is decoded.
   always_comb begin
      nxt_state     = state_ff;
      nxt_bitCnt    = bitCnt_ff;
      nxt_shift     = shift_ff;
      nxt_outShift  = outShift_ff;
      nxt_addr      = addr_ff;
      nxt_count     = count_ff;
      nxt_bytesDone = bytesDone_ff;
      nxt_sdioOut   = sdioOut_ff;
      nxt_sdioOe    = sdioOe_ff;
      nxt_sdoOut    = sdoOut_ff;
      nxt_sdoOe     = sdoOe_ff;
      if (csHigh) begin
         nxt_state  = serial_cfg_pkg::ST_IDLE;
         nxt_bitCnt = 4'h0;
         nxt_sdioOe = 1'b0;
         nxt_sdoOe  = 1'b0;
      end else begin
         case (state_ff)
            serial_cfg_pkg::ST_IDLE: begin
               nxt_state  = serial_cfg_pkg::ST_INSTR;
               nxt_bitCnt = 4'h0;
            end
            serial_cfg_pkg::ST_INSTR: if (sclkRise) begin // RL2
               nxt_shift  = shifted;
               nxt_bitCnt = 4'(bitCnt_ff + 4'h1);
               if (bitCnt_ff == serial_cfg_pkg::LAST_INSTR_BIT) begin
                  nxt_bitCnt    = 4'h0;
                  nxt_addr      = shifted[12:0];
                  nxt_count     = shifted[serial_cfg_pkg::CNT_HI:
                                          serial_cfg_pkg::CNT_LO];
                  nxt_bytesDone = 2'h0;
                  nxt_outShift  = readData(shifted[12:0]); // RL7
                  nxt_state     = shifted[serial_cfg_pkg::INSTR_RW]
                                  ? serial_cfg_pkg::ST_READ
                                  : serial_cfg_pkg::ST_WRITE;
               end
            end
            serial_cfg_pkg::ST_WRITE: if (sclkRise) begin
               nxt_shift  = shifted;
               nxt_bitCnt = 4'(bitCnt_ff + 4'h1);
               if (wrStrobe) begin
                  nxt_bitCnt    = 4'h0;
                  nxt_addr      = stepAddr(addr_ff, lsbFirst); // RL4
                  nxt_bytesDone = 2'(bytesDone_ff + 2'h1);
                  if (lastByte) nxt_state = serial_cfg_pkg::ST_DONE;
               end
            end
            serial_cfg_pkg::ST_READ: if (sclkFall) begin
               // Reads drive on the falling edge so the host samples on rise
               if (cfgAct_ff[serial_cfg_pkg::BIT_SEP_READ]) begin // RL5
                  nxt_sdoOe  = 1'b1;
                  nxt_sdoOut = lsbFirst ? outShift_ff[0] : outShift_ff[7];
               end else begin
                  nxt_sdioOe  = 1'b1;
                  nxt_sdioOut = lsbFirst ? outShift_ff[0] : outShift_ff[7];
               end
               nxt_outShift = lsbFirst ? {1'b0, outShift_ff[7:1]}
                                       : {outShift_ff[6:0], 1'b0};
               nxt_bitCnt = 4'(bitCnt_ff + 4'h1);
               if (bitCnt_ff == serial_cfg_pkg::LAST_BYTE_BIT) begin
                  nxt_bitCnt    = 4'h0;
                  nxt_addr      = stepAddr(addr_ff, lsbFirst); // RL4
                  nxt_outShift  = readData(stepAddr(addr_ff, lsbFirst));
                  nxt_bytesDone = 2'(bytesDone_ff + 2'h1);
                  if (lastByte) nxt_state = serial_cfg_pkg::ST_DONE;
               end
            end
            serial_cfg_pkg::ST_DONE: begin
               // Release the data line after the last bit has been held
               if (sclkFall) begin
                  nxt_sdioOe = 1'b0;
                  nxt_sdoOe  = 1'b0;
               end
            end
            default: nxt_state = serial_cfg_pkg::ST_IDLE;
         endcase
      end
   end

   // Register file: buffer and active copies
   always_comb begin
      nxt_cfgBuf = cfgBuf_ff;
      nxt_cfgAct = cfgAct_ff;
      nxt_rbBuf  = rbBuf_ff;
      nxt_rbAct  = rbAct_ff;
      if (wrStrobe) begin
         case (addr_ff)
            serial_cfg_pkg::ADDR_PORT_CFG: nxt_cfgBuf = wrData; // RL8
            serial_cfg_pkg::ADDR_READBACK: nxt_rbBuf  = wrData; // RL8
            serial_cfg_pkg::ADDR_UPDATE: begin
               if (wrData[serial_cfg_pkg::BIT_UPDATE]) begin // RL8
                  nxt_cfgAct = cfgBuf_ff;
                  nxt_rbAct  = rbBuf_ff;
               end
            end
            default: nxt_cfgBuf = cfgBuf_ff; // RL6
         endcase
      end
      // Reset acts at once, not on update, so it can never lock the port
      if (nxt_cfgBuf[serial_cfg_pkg::BIT_SOFT_RESET]) begin // RL3
         nxt_cfgBuf = serial_cfg_pkg::PORT_CFG_HELD;
         nxt_cfgAct = serial_cfg_pkg::PORT_CFG_RST;
         nxt_rbBuf  = serial_cfg_pkg::READBACK_RST;
         nxt_rbAct  = serial_cfg_pkg::READBACK_RST;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_ff     <= serial_cfg_pkg::ST_IDLE;
         bitCnt_ff    <= 4'h0;
         shift_ff     <= 16'h0000;
         outShift_ff  <= 8'h00;
         addr_ff      <= 13'h0000;
         count_ff     <= 2'h0;
         bytesDone_ff <= 2'h0;
         sdioOut_ff   <= 1'b0;
         sdioOe_ff    <= 1'b0;
         sdoOut_ff    <= 1'b0;
         sdoOe_ff     <= 1'b0;
         cfgBuf_ff    <= serial_cfg_pkg::PORT_CFG_RST; // RL2
         cfgAct_ff    <= serial_cfg_pkg::PORT_CFG_RST;
         rbBuf_ff     <= serial_cfg_pkg::READBACK_RST;
         rbAct_ff     <= serial_cfg_pkg::READBACK_RST;
      end else begin
         state_ff     <= nxt_state;
         bitCnt_ff    <= nxt_bitCnt;
         shift_ff     <= nxt_shift;
         outShift_ff  <= nxt_outShift;
         addr_ff      <= nxt_addr;
         count_ff     <= nxt_count;
         bytesDone_ff <= nxt_bytesDone;
         sdioOut_ff   <= nxt_sdioOut;
         sdioOe_ff    <= nxt_sdioOe;
         sdoOut_ff    <= nxt_sdoOut;
         sdoOe_ff     <= nxt_sdoOe;
         cfgBuf_ff    <= nxt_cfgBuf;
         cfgAct_ff    <= nxt_cfgAct;
         rbBuf_ff     <= nxt_rbBuf;
         rbAct_ff     <= nxt_rbAct;
      end
   end

   assign sdioOut               = sdioOut_ff;
   assign sdioOe                = sdioOe_ff;
   assign serialReadOutPin      = sdoOut_ff;
   assign separateReadPinEnable = sdoOe_ff;
   assign activePortCfg         = cfgAct_ff;
   assign activeReadback        = rbAct_ff;
   assign softResetHeld         = cfgBuf_ff[serial_cfg_pkg::BIT_SOFT_RESET];

   logic wrPort, wrUpd;
   assign wrPort = wrStrobe && (addr_ff == serial_cfg_pkg::ADDR_PORT_CFG);
   assign wrUpd  = wrStrobe && (addr_ff == serial_cfg_pkg::ADDR_UPDATE);

   property p_variant_ro;
      @(posedge clock) disable iff (rst)
      wrStrobe && (addr_ff == serial_cfg_pkg::ADDR_VARIANT)
      |=> $stable(cfgBuf_ff) && $stable(rbBuf_ff) && $stable(cfgAct_ff);
   endproperty
   a_variant_ro: assert property (p_variant_ro) // RL6
      else $error("variant write changed a register");

   property p_buffer_only;
      @(posedge clock) disable iff (rst)
      wrPort && !wrData[serial_cfg_pkg::BIT_SOFT_RESET]
      |=> cfgBuf_ff == $past(wrData) && cfgAct_ff == $past(cfgAct_ff);
   endproperty
   a_buffer_only: assert property (p_buffer_only) // RL8
      else $error("write did not land in buffer only");

   property p_update_copy;
      @(posedge clock) disable iff (rst)
      wrUpd && wrData[serial_cfg_pkg::BIT_UPDATE] && !softResetHeld
      |=> cfgAct_ff == $past(cfgBuf_ff) && rbAct_ff == $past(rbBuf_ff);
   endproperty
   a_update_copy: assert property (p_update_copy) // RL8
      else $error("update did not copy buffer to active");

   property p_soft_defaults;
      @(posedge clock) disable iff (rst)
      softResetHeld |=> cfgAct_ff == serial_cfg_pkg::PORT_CFG_RST
                        && rbAct_ff == serial_cfg_pkg::READBACK_RST;
   endproperty
   a_soft_defaults: assert property (p_soft_defaults) // RL3
      else $error("soft reset did not restore defaults");

   property p_soft_sticky;
      @(posedge clock) disable iff (rst)
      softResetHeld && !wrPort |=> softResetHeld;
   endproperty
   a_soft_sticky: assert property (p_soft_sticky) // RL3
      else $error("soft reset cleared itself");

   property p_sdo_mode;
      @(posedge clock) disable iff (rst)
      $rose(sdoOe_ff)
      |-> cfgAct_ff[serial_cfg_pkg::BIT_SEP_READ] && !sdioOe_ff;
   endproperty
   a_sdo_mode: assert property (p_sdo_mode) // RL5
      else $error("separate read pin driven in shared mode");

   property p_sdio_mode;
      @(posedge clock) disable iff (rst)
      $rose(sdioOe_ff) |-> !cfgAct_ff[serial_cfg_pkg::BIT_SEP_READ];
   endproperty
   a_sdio_mode: assert property (p_sdio_mode) // RL5
      else $error("data pin driven for read in separate mode");

   property p_addr_step;
      @(posedge clock) disable iff (rst)
      wrStrobe && !csHigh |=> addr_ff == ($past(lsbFirst)
         ? 13'($past(addr_ff) + 13'h1) : 13'($past(addr_ff) - 13'h1));
   endproperty
   a_addr_step: assert property (p_addr_step) // RL4
      else $error("address stepped the wrong way");

   c_read_frame: cover property (@(posedge clock) disable iff (rst)
      state_ff == serial_cfg_pkg::ST_READ ##1
      state_ff == serial_cfg_pkg::ST_DONE);
   c_update: cover property (@(posedge clock) disable iff (rst) wrUpd);
   c_soft: cover property (@(posedge clock) disable iff (rst)
      $fell(softResetHeld));
   c_lsb_write: cover property (@(posedge clock) disable iff (rst)
      wrStrobe && lsbFirst);

endmodule : serial_config_port

`default_nettype wire

//--- tb_serial_config_port.sv
// Self-checking bench for the serial configuration port.
// Assumes the host model paces every frame from the bench clock.
`timescale 1ns/1ps
`default_nettype none

module tb_serial_config_port;
   // Arbitrary value, not a real part code
   localparam logic [7:0] ID_VALUE = 8'h5C;
   localparam int         LIMIT    = 20000;

   logic       clock;
   logic       rst;
   logic       sclk;
   logic       csN;
   logic       hostBit;
   logic       hostOe;
   logic       sdioOut;
   logic       sdioOe;
   logic       readPin;
   logic       readPinEn;
   logic       softHeld;
   logic [7:0] actCfg;
   logic [7:0] actRb;
   logic [7:0] d;
   logic [15:0] r;
   wire        dataWire;
   wire        readPinWire;
   int         nFail = 0;
   int         checksDone = 0;
   int         cycles = 0;

   // Released lines show the inverse of the last host bit, never a hold
   assign dataWire = sdioOe ? sdioOut : (hostOe ? hostBit : ~hostBit);
   assign readPinWire = readPinEn ? readPin : ~hostBit;

   serial_config_port #(.VARIANT_ID(ID_VALUE)) dut (
      .clock(clock), .rst(rst), .sclk(sclk), .csN(csN), .sdioIn(dataWire),
      .sdioOut(sdioOut), .sdioOe(sdioOe), .serialReadOutPin(readPin),
      .separateReadPinEnable(readPinEn), .activePortCfg(actCfg),
      .activeReadback(actRb), .softResetHeld(softHeld));

   host_model host (
      .clock(clock), .dataWire(dataWire), .readPinWire(readPinWire),
      .sclk(sclk), .csN(csN), .hostBit(hostBit), .hostOe(hostOe));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic finish_test;
      if (nFail == 0 && checksDone > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checksDone++;
      if (got !== exp) begin
         nFail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic lsb, input logic [12:0] a,
                     input logic [7:0] v);
      host.frame(lsb, 1'b0, {3'h0, a}, 1, {8'h00, v}, r);
   endtask : wr

   task automatic rd(input logic lsb, input logic sep, input logic [12:0] a);
      host.frame(lsb, sep, {3'h4, a}, 1, 16'h0000, r);
      d = r[7:0];
   endtask : rd

   // Pin watch and hang guard, sampled where registered outputs are settled
   always @(negedge clock) begin
      cycles++;
      if (!rst && actCfg[0] === 1'b0) begin
         check({7'h00, readPinEn}, 8'h00);
      end
      if (!rst && actCfg[0] === 1'b1) begin
         check({7'h00, sdioOe}, 8'h00);
      end
      if (cycles >= LIMIT) begin
         nFail++;
         finish_test();
      end
   end

   task automatic test_defaults;
      check(actCfg, 8'h18);
      check(actRb, 8'h00);
      check({7'h00, softHeld}, 8'h00);
      rd(1'b0, 1'b0, 13'h000);
      check(d, 8'h18);
      rd(1'b0, 1'b0, 13'h010);
      check(d, 8'h00);
   endtask : test_defaults

   task automatic test_ident;
      rd(1'b0, 1'b0, 13'h003);
      check(d, ID_VALUE);
      wr(1'b0, 13'h003, 8'h00);
      rd(1'b0, 1'b0, 13'h003);
      check(d, ID_VALUE);
   endtask : test_ident

   task automatic test_buffers;
      wr(1'b0, 13'h004, 8'h01);
      check(actRb, 8'h00);
      rd(1'b0, 1'b0, 13'h004);
      check(d, 8'h01);
      wr(1'b0, 13'h232, 8'h01);
      check(actRb, 8'h01);
      wr(1'b0, 13'h004, 8'h00);
      rd(1'b0, 1'b0, 13'h004);
      check(d, 8'h01);
      wr(1'b0, 13'h232, 8'h01);
      check(actRb, 8'h00);
      rd(1'b0, 1'b0, 13'h004);
      check(d, 8'h00);
   endtask : test_buffers

   // A two-byte read from 004 and two-byte writes from 005 and 003 show the step way
   task automatic test_order;
      host.frame(1'b0, 1'b0, {3'h5, 13'h004}, 2, 16'h0000, r);
      check(r[7:0], 8'h00);
      check(r[15:8], ID_VALUE);
      host.frame(1'b0, 1'b0, {3'h1, 13'h005}, 2, 16'h0100, r);
      rd(1'b0, 1'b0, 13'h004);
      check(d, 8'h01);
      wr(1'b0, 13'h004, 8'h00);
      wr(1'b0, 13'h000, 8'hDB);
      check(actCfg, 8'h18);
      wr(1'b0, 13'h232, 8'h01);
      check(actCfg, 8'hDB);
      rd(1'b1, 1'b1, 13'h003);
      check(d, ID_VALUE);
      host.frame(1'b1, 1'b1, {3'h1, 13'h003}, 2, 16'h01AA, r);
      rd(1'b1, 1'b1, 13'h004);
      check(d, 8'h01);
      wr(1'b1, 13'h000, 8'h18);
      wr(1'b1, 13'h232, 8'h01);
      check(actCfg, 8'h18);
   endtask : test_order

   task automatic test_soft_reset;
      wr(1'b0, 13'h232, 8'h01);
      check(actRb, 8'h01);
      wr(1'b0, 13'h000, 8'h3C);
      check({7'h00, softHeld}, 8'h01);
      check(actRb, 8'h00);
      rd(1'b0, 1'b0, 13'h004);
      check(d, 8'h00);
      rd(1'b0, 1'b0, 13'h000);
      check(d, 8'h3C);
      wr(1'b0, 13'h000, 8'h18);
      check({7'h00, softHeld}, 8'h00);
      check(actCfg, 8'h18);
   endtask : test_soft_reset

   // A hard reset in mid-run must drop both copies back to defaults
   task automatic test_hard_reset;
      wr(1'b0, 13'h004, 8'h01);
      wr(1'b0, 13'h232, 8'h01);
      check(actRb, 8'h01);
      rst = 1'b1;
      repeat (2) @(posedge clock);
      #1;
      rst = 1'b0;
      repeat (4) @(posedge clock);
      #1;
      check(actRb, 8'h00);
      check(actCfg, 8'h18);
      check({7'h00, softHeld}, 8'h00);
      rd(1'b0, 1'b0, 13'h004);
      check(d, 8'h00);
   endtask : test_hard_reset

   initial begin
      rst = 1'b1;
      repeat (16) @(posedge clock);
      #1;
      rst = 1'b0;
      repeat (4) @(posedge clock);
      #1;
      test_defaults();
      test_ident();
      test_buffers();
      test_order();
      test_soft_reset();
      test_hard_reset();
      finish_test();
   end
endmodule : tb_serial_config_port
`default_nettype wire
